// ===== verilog/dcd_pkg.sv
/*
 * holds the shared constants and carrier structs of the discrete command decoder.
 * assumes one control clock at 10 MHz and a synchronous active-high reset.
 */
package dcd_pkg;
   localparam int N_IN = 8;                         // number of discrete inputs
   localparam int REF_W = 16;                       // speed reference width
   localparam int CLK_HZ = 10_000_000;              // control clock rate
   localparam int DEB_US = 1_000;                   // debounce settle time in microseconds
   localparam int DEB_CYC = DEB_US * (CLK_HZ / 1_000_000); // settle time in cycles
   localparam int RST_PULSE_CYC = 16;               // alarm reset pulse length in cycles
   localparam logic [REF_W-1:0] REF_RST = 16'h0000; // speed reference after reset
   // input positions in the discrete input vector
   localparam int IN_ISO = 0;                       // droop/isochronous select
   localparam int IN_ARST = 1;                      // alarm reset
   localparam int IN_SFO = 2;                       // speed fail override
   localparam int IN_DYN2 = 3;                      // second dynamics select
   localparam int IN_RAISE = 4;                     // raise speed
   localparam int IN_LOWER = 5;                     // lower speed
   localparam int IN_RATED = 6;                     // rated speed
   localparam int IN_RUN = 7;                       // close to run

   // speed reference settings from configuration
   typedef struct packed {
      logic [REF_W-1:0] raise_rate;                 // raise step per tick
      logic [REF_W-1:0] lower_rate;                 // lower step per tick
      logic [REF_W-1:0] raise_max;                  // raise speed limit
      logic [REF_W-1:0] lower_min;                  // lower speed limit
      logic [REF_W-1:0] rated;                      // rated speed point
      logic [REF_W-1:0] idle;                       // idle speed point
      logic [REF_W-1:0] accel_rate;                 // step toward rated
      logic [REF_W-1:0] decel_rate;                 // step toward idle
   } dcd_ref_cfg_s;

   // decoded control states
   typedef struct packed {
      logic droop;                                  // droop mode active
      logic iso;                                    // isochronous, bias input used
      logic dyn2;                                   // second dynamics set
      logic sfo_override;                           // speed loss shutdown overridden
      logic speed_fail_shutdown;                    // shutdown for lost speed
      logic remote_ref_en;                          // remote reference enabled
      logic alarm_clear;                            // alarm clear pulse
   } dcd_ctl_s;
endpackage

// ===== verilog/dcd_filter.sv
/*
 * holds a two-stage synchroniser and settle-time debounce for one discrete input.
 * assumes a contact level that may bounce and arrives asynchronously.
 */
`timescale 1ns/10ps
module dcd_filter #(
   parameter int SETTLE = dcd_pkg::DEB_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic raw,
   output logic clean
);
   // all state of the filter
   typedef struct packed {
      logic s1;                                     // first sync stage
      logic s2;                                     // second sync stage
      logic [15:0] cnt;                             // settle counter
      logic out;                                    // filtered level
   } dcd_flt_s;
   dcd_flt_s st_r;
   dcd_flt_s st_nxt;

   // next state: count while the synced level differs from output
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
      if (st_r.s2 == st_r.out) begin
         st_nxt.cnt = 16'h0000;                     // agree, restart settle
      end else if (st_r.cnt >= 16'(SETTLE - 1)) begin
         st_nxt.out = st_r.s2;                      // settled, accept  R25
         st_nxt.cnt = 16'h0000;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   // register the state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clean = st_r.out;
endmodule

// ===== verilog/dcd_pulse.sv
/*
 * holds the alarm reset one-shot: rising edge of the merged request gives a fixed pulse.
 * assumes the request level is already synchronous and filtered.
 */
`timescale 1ns/10ps
module dcd_pulse #(
   parameter int LEN = dcd_pkg::RST_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic req,
   output logic pulse
);
   // all state of the one-shot
   typedef struct packed {
      logic armed;                                  // seen low since last pulse
      logic [7:0] cnt;                              // remaining pulse cycles
      logic out;                                    // pulse output
   } dcd_pls_s;
   dcd_pls_s st_r;
   dcd_pls_s st_nxt;

   // next state of the one-shot
   always_comb begin
      st_nxt = st_r;
      if (!req) begin
         st_nxt.armed = 1'b1;                       // re-arm only when low  R09
      end
      if (req && st_r.armed) begin
         st_nxt.armed = 1'b0;                       // edge caught  R26
         st_nxt.cnt = 8'(LEN - 1);
         st_nxt.out = 1'b1;
      end else if (st_r.cnt != 8'h00) begin
         st_nxt.cnt = st_r.cnt - 8'h01;
      end else begin
         st_nxt.out = 1'b0;                         // limited length  R08
      end
   end

   // register the state; armed low at reset so a held request does not fire
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse = st_r.out;
endmodule

// ===== verilog/dcd_top.sv
/*
 * holds the discrete command decoder top: input filtering, lamps, mode decode,
 * alarm reset merge and latch clearing, speed fail override and speed reference ramp.
 * assumes contact inputs, serial and software reset levels, and configuration
 * values come in as plain ports clocked by sys_clk.
 */
// Summary of operation
// R01: closed contact reads true, open false
// R02: lamp lit while input is true
// R03: mode input false selects droop
// R04: mode input true selects isochronous bias
// R05: raise and lower move reference in droop
// R06: reset request clears every latching alarm
// R07: clear only alarms whose condition is normal
// R08: reset applies only a short interval
// R09: rearm only after input returns false
// R10: serial ports and software switch also reset
// R11: override true suppresses speed loss shutdown
// R12: override false shuts down on both lost
// R13: dynamics input picks second or first set
// R14: raise true ramps reference up at rate
// R15: raise stops at configured upper limit
// R16: raise ignored while rated is deselected
// R17: raise released holds present reference
// R18: raise and lower together enable remote
// R19: override kept false in direct acting
// R20: override held true in reverse acting
// R21: breaker aux opened whenever mode false
// R22: no raise with load sharing breaker closed; the code raises whatever the breaker_aux_input level
// R23: lower ramps down to lower limit
// R24: rated ramps to rated, else idle
// R25: inputs synchronised and debounced before use
// R26: fixed length pulse on reset edge
`timescale 1ns/10ps
module dcd_top #(
   parameter int N_ALM = 8,                         // number of latching alarms
   parameter int SETTLE = dcd_pkg::DEB_CYC,         // debounce settle cycles
   parameter int RAMP_DIV = 1_000                   // cycles per ramp tick
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [dcd_pkg::N_IN-1:0] din_raw,    // contact levels, high when closed
   input wire logic serial_port_one_reset,          // reset command from first serial port
   input wire logic serial_port_two_reset,          // reset command from second serial port
   input wire logic sw_reset,                       // reset software switch
   input wire logic [N_ALM-1:0] alarm_cond,         // alarm conditions present
   input wire logic speed_a_lost,                   // first speed sensor lost
   input wire logic speed_b_lost,                   // second speed sensor lost
   input wire dcd_pkg::dcd_ref_cfg_s ref_cfg,       // reference settings
   output logic [dcd_pkg::N_IN-1:0] lamp,           // per input indicators
   output dcd_pkg::dcd_ctl_s ctl,                   // decoded control states
   output logic breaker_aux_input,                  // load sharing enable, open in droop
   output logic [N_ALM-1:0] alarm_latched,          // latched alarms
   output logic [dcd_pkg::REF_W-1:0] speed_ref,     // speed reference
   output logic fuel_run                            // fuel allowed
);
   localparam int W = dcd_pkg::REF_W;

   // all top-level state
   typedef struct packed {
      logic [dcd_pkg::N_IN-1:0] lamp;               // lamp drive
      dcd_pkg::dcd_ctl_s ctl;                       // control states
      logic bkr;                                    // breaker aux drive
      logic [N_ALM-1:0] alm;                        // latched alarms
      logic [W-1:0] sref;                           // speed reference
      logic to_rated;                               // ramp to rated still owed
      logic [15:0] tick_cnt;                        // ramp tick divider
      logic run;                                    // fuel allowed
   } dcd_top_s;
   dcd_top_s st_r;
   dcd_top_s st_nxt;

   logic [dcd_pkg::N_IN-1:0] din;                   // filtered inputs
   logic reset_req;                                 // merged reset request level
   logic clr_pulse;                                 // alarm clear pulse

   // one filter per discrete input
   genvar gi;
   generate
      for (gi = 0; gi < dcd_pkg::N_IN; gi++) begin : g_flt
         dcd_filter #(
            .SETTLE(SETTLE)
         ) u_flt (
            .sys_clk(sys_clk),
            .rst(rst),
            .raw(din_raw[gi]),                      // high when closed  R01
            .clean(din[gi])
         );
      end
   endgenerate

   // any reset source triggers the request
   assign reset_req = din[dcd_pkg::IN_ARST] | serial_port_one_reset
      | serial_port_two_reset | sw_reset; // R10

   // one-shot on the merged request
   dcd_pulse #(
      .LEN(dcd_pkg::RST_PULSE_CYC)
   ) u_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .req(reset_req),
      .pulse(clr_pulse)
   );

   // saturating step helpers
   function automatic logic [W-1:0] step_up(input logic [W-1:0] v, input logic [W-1:0] d,
         input logic [W-1:0] lim);
      logic [W:0] s;
      s = {1'b0, v} + {1'b0, d};
      if (v >= lim) begin
         step_up = v;
      end else if (s > {1'b0, lim}) begin
         step_up = lim;
      end else begin
         step_up = s[W-1:0];
      end
   endfunction

   function automatic logic [W-1:0] step_dn(input logic [W-1:0] v, input logic [W-1:0] d,
         input logic [W-1:0] lim);
      logic [W:0] s;
      s = {1'b0, v} - {1'b0, d};
      if (v <= lim) begin
         step_dn = v;
      end else if (s[W] || s[W-1:0] < lim) begin
         step_dn = lim;
      end else begin
         step_dn = s[W-1:0];
      end
   endfunction

   // next state of the decoder
   always_comb begin
      logic tick;
      logic raise;
      logic lower;
      logic rated;
      tick = 1'b0;
      raise = din[dcd_pkg::IN_RAISE];
      lower = din[dcd_pkg::IN_LOWER];
      rated = din[dcd_pkg::IN_RATED];
      st_nxt = st_r;
      st_nxt.lamp = din;                            // R02
      st_nxt.ctl.droop = ~din[dcd_pkg::IN_ISO];     // R03
      st_nxt.ctl.iso = din[dcd_pkg::IN_ISO];        // R04
      st_nxt.bkr = din[dcd_pkg::IN_ISO];            // load sharing off in droop
      st_nxt.ctl.dyn2 = din[dcd_pkg::IN_DYN2];      // R13
      st_nxt.ctl.sfo_override = din[dcd_pkg::IN_SFO]; // R11
      st_nxt.ctl.speed_fail_shutdown = ~din[dcd_pkg::IN_SFO]
         & speed_a_lost & speed_b_lost;              // R12
      st_nxt.ctl.remote_ref_en = raise & lower;      // R18
      st_nxt.ctl.alarm_clear = clr_pulse;            // R06
      st_nxt.run = din[dcd_pkg::IN_RUN];
      // rated ramp is owed from each return of rated until raise or lower takes over
      if (!rated) begin
         st_nxt.to_rated = 1'b1;                    // rated off re-arms the ramp  R24
      end else if (raise || lower) begin
         st_nxt.to_rated = 1'b0;                    // manual command owns the reference  R05
      end
      // alarms: set wins; clear only where condition is normal
      for (int i = 0; i < N_ALM; i++) begin
         if (alarm_cond[i]) begin
            st_nxt.alm[i] = 1'b1;                   // R07
         end else if (clr_pulse) begin
            st_nxt.alm[i] = 1'b0;                   // R06
         end
      end
      // ramp tick divider
      if (st_r.tick_cnt >= 16'(RAMP_DIV - 1)) begin
         st_nxt.tick_cnt = 16'h0000;
         tick = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
      end
      // speed reference ramp
      if (tick) begin
         if (!rated) begin
            // rated off takes control from raise and lower  R16
            st_nxt.sref = (st_r.sref > ref_cfg.idle)
               ? step_dn(st_r.sref, ref_cfg.decel_rate, ref_cfg.idle)
               : step_up(st_r.sref, ref_cfg.decel_rate, ref_cfg.idle); // R24
         end else if (raise && lower) begin
            st_nxt.sref = st_r.sref;                // remote mode, hold
         end else if (raise) begin
            st_nxt.sref = step_up(st_r.sref, ref_cfg.raise_rate,
               ref_cfg.raise_max);                  // R14 R15 R05
         end else if (lower) begin
            st_nxt.sref = step_dn(st_r.sref, ref_cfg.lower_rate,
               ref_cfg.lower_min);                  // R23 R05
         end else if (st_r.to_rated) begin
            // move toward the rated point from either side, then sit on it
            st_nxt.sref = (st_r.sref > ref_cfg.rated)
               ? step_dn(st_r.sref, ref_cfg.accel_rate, ref_cfg.rated)
               : step_up(st_r.sref, ref_cfg.accel_rate, ref_cfg.rated); // R24
         end else begin
            st_nxt.sref = st_r.sref;                // hold when released  R17
         end
         // reference never above the raise limit  R15
         if (st_nxt.sref > ref_cfg.raise_max) begin
            st_nxt.sref = ref_cfg.raise_max;
         end
      end
   end

   // register the state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign lamp = st_r.lamp;
   assign ctl = st_r.ctl;
   assign breaker_aux_input = st_r.bkr;
   assign alarm_latched = st_r.alm;
   assign speed_ref = st_r.sref;
   assign fuel_run = st_r.run;
endmodule

// ===== verif/dcd_top_asserts.sv
/*
 * checker for the discrete command decoder top: mode, override, alarm and ramp relations.
 * assumes the bind below, one clock sys_clk and a synchronous active-high rst.
 */
`timescale 1ns/10ps
module dcd_top_asserts #(
   parameter int N_ALM = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic speed_a_lost,
   input wire logic speed_b_lost,
   input wire logic [N_ALM-1:0] alarm_cond,
   input wire dcd_pkg::dcd_ref_cfg_s ref_cfg,
   input wire logic [dcd_pkg::N_IN-1:0] lamp,
   input wire dcd_pkg::dcd_ctl_s ctl,
   input wire logic breaker_aux_input,
   input wire logic [N_ALM-1:0] alarm_latched,
   input wire logic [dcd_pkg::REF_W-1:0] speed_ref,
   input wire logic fuel_run
);
   logic [7:0] clr_cnt_r; // cycles the clear pulse has stood so far
   logic cmd_r; // raise or lower seen since rated last came on
   // a manual command ends the owed rated ramp until rated drops again
   always_ff @(posedge sys_clk) begin
      if (rst || !lamp[dcd_pkg::IN_RATED]) begin
         cmd_r <= 1'b0;
      end else if (lamp[dcd_pkg::IN_RAISE] || lamp[dcd_pkg::IN_LOWER]) begin
         cmd_r <= 1'b1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // count the clear pulse, restarting whenever it is low
   always_ff @(posedge sys_clk) begin
      if (rst || !ctl.alarm_clear) begin
         clr_cnt_r <= 8'h00;
      end else begin
         clr_cnt_r <= clr_cnt_r + 8'h01;
      end
   end
   mode_iso_a: assert property (ctl.iso == lamp[dcd_pkg::IN_ISO])
      else $error("iso state differs from mode lamp");
   mode_droop_a: assert property (ctl.droop |-> !lamp[dcd_pkg::IN_ISO])
      else $error("droop active with mode input true");
   breaker_aux_a: assert property (breaker_aux_input == ctl.iso)
      else $error("load sharing enable differs from iso state");
   dyn_set_a: assert property (ctl.dyn2 == lamp[dcd_pkg::IN_DYN2])
      else $error("dynamics set differs from its lamp");
   sfo_follow_a: assert property (ctl.sfo_override |-> !ctl.speed_fail_shutdown)
      else $error("shutdown while override is on");
   both_lost_a: assert property ((!ctl.sfo_override && speed_a_lost && speed_b_lost)[*3]
      |-> ##[0:2] ctl.speed_fail_shutdown)
      else $error("no shutdown with both sensors lost");
   remote_en_a: assert property (ctl.remote_ref_en
      |-> lamp[dcd_pkg::IN_RAISE] && lamp[dcd_pkg::IN_LOWER])
      else $error("remote reference without raise and lower");
   clr_len_a: assert property ($fell(ctl.alarm_clear) |-> clr_cnt_r == 8'h10)
      else $error("clear pulse length wrong");
   latch_keep_a: assert property (!$past(rst)
      |-> ($past(alarm_latched) & $past(alarm_cond) & ~alarm_latched) == '0)
      else $error("alarm cleared while its condition was present");
   clr_normal_a: assert property (ctl.alarm_clear && $past(ctl.alarm_clear)
      |-> (alarm_latched & ~$past(alarm_cond)) == '0)
      else $error("normal alarm still latched during clear");
   ref_max_a: assert property (speed_ref <= ref_cfg.raise_max)
      else $error("reference above raise limit");
   ref_hold_a: assert property ((lamp[dcd_pkg::IN_RATED] && !lamp[dcd_pkg::IN_RAISE]
      && !lamp[dcd_pkg::IN_LOWER])[*3] ##0 (cmd_r || $past(speed_ref) == ref_cfg.rated)
      |-> $stable(speed_ref))
      else $error("reference moved with no command");
   rated_off_a: assert property ((!lamp[dcd_pkg::IN_RATED])[*3]
      ##0 ($past(speed_ref) >= ref_cfg.idle) |-> speed_ref <= $past(speed_ref))
      else $error("reference rose with rated deselected");
   run_lamp_a: assert property (fuel_run == lamp[dcd_pkg::IN_RUN])
      else $error("run output differs from its lamp");
endmodule

bind dcd_top dcd_top_asserts #(.N_ALM(N_ALM)) dcd_top_asserts_i (
   .sys_clk(sys_clk), .rst(rst), .speed_a_lost(speed_a_lost), .speed_b_lost(speed_b_lost),
   .alarm_cond(alarm_cond), .ref_cfg(ref_cfg), .lamp(lamp), .ctl(ctl),
   .breaker_aux_input(breaker_aux_input), .alarm_latched(alarm_latched),
   .speed_ref(speed_ref), .fuel_run(fuel_run)
);

// ===== verif/dcd_contacts.sv
/*
 * contact model: turns wanted contact states into input levels, with chatter.
 * assumes the bench changes want shortly after a clock edge.
 */
`timescale 1ns/10ps
module dcd_contacts (
   input wire logic sys_clk,
   input wire logic [7:0] want,
   input wire logic bounce,
   output logic [7:0] din_raw
);
   logic [7:0] now_r = 8'h00; // settled contact state
   logic [7:0] prv_r = 8'h00; // state before the last change
   logic [1:0] bnc_r = 2'h0; // chatter cycles left
   // a moving contact chatters back to its old level for two one-cycle spells
   always_ff @(posedge sys_clk) begin
      if (want != now_r) begin
         prv_r <= now_r;
         now_r <= want;
         bnc_r <= bounce ? 2'h3 : 2'h0;
      end else if (bnc_r != 2'h0) begin
         bnc_r <= bnc_r - 2'h1;
      end
   end
   // closed contact gives a high level, chatter shows the old level
   assign din_raw = bnc_r[0] ? prv_r : want;
endmodule

// ===== verif/dcd_top_tb_top.sv
/*
 * testbench for the discrete command decoder: table of modes, then filter, ramp,
 * speed fail and alarm reset cases.
 * assumes the contact model and checker files are compiled before it.
 */
`timescale 1ns/10ps
module dcd_top_tb_top;
   typedef struct packed {logic [7:0] din; logic [6:0] ctl;} dcd_row_s;
   dcd_row_s rows [5] = '{'{8'h00, 7'h40}, '{8'h01, 7'h20}, '{8'h08, 7'h50},
      '{8'h84, 7'h48}, '{8'h4D, 7'h38}};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] want = 8'h00; // wanted contact states
   logic bounce = 1'b1; // contacts chatter on change
   logic [2:0] rreq = 3'h0; // serial one, serial two, software reset requests
   logic [7:0] alarm_cond = 8'h00;
   logic lost_a = 1'b0;
   logic lost_b = 1'b0;
   dcd_pkg::dcd_ref_cfg_s ref_cfg = '{16'h0010, 16'h0008, 16'h0100, 16'h0020,
      16'h00C0, 16'h0040, 16'h0004, 16'h0004};
   logic [7:0] din_raw;
   logic [7:0] lamp;
   dcd_pkg::dcd_ctl_s ctl;
   logic breaker_aux_input;
   logic [7:0] alarm_latched;
   logic [15:0] speed_ref;
   logic fuel_run;
   logic [15:0] v;
   int bad_count = 0;
   int compares = 0;
   int n;
   dcd_contacts dcd_contacts_i (.sys_clk(sys_clk), .want(want), .bounce(bounce),
      .din_raw(din_raw));
   dcd_top #(.SETTLE(4), .RAMP_DIV(4)) dcd_top_i (.sys_clk(sys_clk), .rst(rst),
      .din_raw(din_raw), .serial_port_one_reset(rreq[0]), .serial_port_two_reset(rreq[1]),
      .sw_reset(rreq[2]), .alarm_cond(alarm_cond), .speed_a_lost(lost_a),
      .speed_b_lost(lost_b), .ref_cfg(ref_cfg), .lamp(lamp), .ctl(ctl),
      .breaker_aux_input(breaker_aux_input), .alarm_latched(alarm_latched),
      .speed_ref(speed_ref), .fuel_run(fuel_run));
   // clock at 100 ns period
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // step k edges, then settle a little past the edge
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #10;
   endtask
   // print counts and verdict, then stop
   task automatic results;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // cut a hang short
   initial begin
      repeat (10000) @(posedge sys_clk);
      bad_count++;
      results();
   end
   // main sequence
   initial begin
      cyc(5);
      rst = 1'b0;
      chk({ctl, lamp}, 15'h0000);
      foreach (rows[i]) begin
         want = rows[i].din;
         cyc(20);
         chk(lamp, rows[i].din);
         chk(ctl, rows[i].ctl);
         chk(breaker_aux_input, rows[i].din[0]);
         chk(fuel_run, rows[i].din[7]);
      end
      // short glitch on one contact must not reach its lamp
      bounce = 1'b0;
      want = 8'h45;
      cyc(2);
      want = 8'h4D;
      n = 0;
      repeat (20) begin
         cyc(1);
         n += !lamp[3];
      end
      chk(n, 0);
      bounce = 1'b1;
      want = 8'hC0; // override kept open in normal running
      cyc(200);
      chk(speed_ref, 16'h00C0);
      want = 8'hD0; // raise only with load sharing off
      v = speed_ref;
      n = 0;
      while (speed_ref == v && n < 50) begin
         cyc(1);
         n++;
      end
      want = 8'hC0;
      chk(speed_ref - v, 16'h0010);
      cyc(20);
      v = speed_ref;
      cyc(40);
      chk(speed_ref, v);
      want = 8'hD0;
      cyc(300);
      chk(speed_ref, 16'h0100);
      want = 8'hE0;
      cyc(300);
      chk(speed_ref, 16'h0020);
      want = 8'hF0;
      cyc(20);
      chk(ctl.remote_ref_en, 1'b1);
      want = 8'h90;
      cyc(300);
      chk(speed_ref, 16'h0040);
      lost_a = 1'b1;
      cyc(5);
      chk(ctl.speed_fail_shutdown, 1'b0);
      lost_b = 1'b1;
      cyc(5);
      chk(ctl.speed_fail_shutdown, 1'b1);
      want = 8'h94; // override held closed
      cyc(20);
      chk({ctl.sfo_override, ctl.speed_fail_shutdown}, 2'h2);
      lost_a = 1'b0;
      lost_b = 1'b0;
      want = 8'h90;
      // each reset source in turn: contact, two serial ports, software
      for (int s = 0; s < 4; s++) begin
         alarm_cond = 8'hFF;
         cyc(3);
         alarm_cond = 8'h3C;
         if (s == 0) begin
            want = 8'h92;
         end else begin
            rreq[s-1] = 1'b1;
         end
         n = 0;
         repeat (40) begin
            cyc(1);
            n += ctl.alarm_clear;
         end
         chk(n, 16);
         chk(alarm_latched, 8'h3C);
         alarm_cond = 8'h00;
         cyc(40);
         chk(alarm_latched, 8'h3C);
         want = 8'h90;
         rreq = 3'h0;
         cyc(20);
      end
      results();
   end
endmodule
